//--- design/acc_regs.vh
// Register offsets, field positions, reset values and timing counts
`ifndef ACC_REGS_VH
`define ACC_REGS_VH

`define ACC_ADDR_W             10
`define ACC_OFS_CFG_A          10'h050
`define ACC_OFS_CFG_B          10'h051
`define ACC_OFS_BG_CTRL        10'h057
`define ACC_OFS_PAT_OVR        10'h058
`define ACC_OFS_VECTOR         10'h05A
`define ACC_OFS_STATUS         10'h05B

`define ACC_RST_CFG_A          8'h06
`define ACC_RST_CFG_B          8'hF4
`define ACC_RST_BG_CTRL        8'h10
`define ACC_RST_PAT_OVR        8'h00
`define ACC_STATUS_FIXED       8'h08

`define ACC_BIT_TIME_STAMP_EN  5
`define ACC_BIT_VEC_ACCESS_EN  4
`define ACC_BIT_FG_TRIGGER     3
`define ACC_FLD_RANGE_HI       6
`define ACC_FLD_RANGE_LO       4
`define ACC_BIT_BG_RUN         1
`define ACC_BIT_BG_MODE        0
`define ACC_BIT_TEST_PATTERN   2
`define ACC_BIT_OVER_RANGE     1
`define ACC_BIT_STAT_CAL_OFF   1
`define ACC_BIT_STAT_FIRST     0

`define ACC_VEC_DEPTH          16
`define ACC_VEC_PTR_W          4
`define ACC_SAMPLE_W           12

// Sequence lengths in clock cycles at 100 MHz
`define ACC_FG_CAL_CYCLES      8'h40
`define ACC_BG_STEP_CYCLES     8'h10

`endif

//--- design/acc_vec_mem.v
// Calibration vector store with registered read data
`timescale 1ns/1ns
module acc_vec_mem
(
  input  wire       clk_in,
  input  wire       wr_en_in,
  input  wire [3:0] wr_addr_in,
  input  wire [7:0] wr_data_in,
  input  wire [3:0] rd_addr_in,
  output reg  [7:0] rd_data_out
);

  reg [7:0] mem_reg [0:15];

  always @(posedge clk_in)
  begin
    if (wr_en_in)
    begin
      mem_reg[wr_addr_in] <= wr_data_in;
    end
    rd_data_out <= mem_reg[rd_addr_in];
  end

endmodule

//--- design/acc_cal_ctrl.v
// Calibration control register bank with calibration sequencer
`timescale 1ns/1ns
`include "acc_regs.vh"

module acc_cal_ctrl
(
  input  wire                     CLK_IN,
  input  wire                     RESET_IN,
  input  wire [`ACC_ADDR_W-1:0]   REG_ADDR_IN,
  input  wire                     REG_WR_IN,
  input  wire                     REG_RD_IN,
  input  wire [7:0]               REG_WDATA_IN,
  output reg  [7:0]               REG_RDATA_OUT,
  input  wire                     TIME_STAMP_IN,
  input  wire [`ACC_SAMPLE_W-1:0] SAMPLE_IN,
  input  wire                     OVER_RANGE_IN,
  output reg  [`ACC_SAMPLE_W-1:0] DATA_OUT,
  output reg                      TIME_STAMP_OUT,
  output reg                      OVER_RANGE_OUT,
  output reg  [2:0]               SIGNAL_RANGE_OPTIMIZE_OUT,
  output reg                      CAL_RUNNING_OUT
);

  localparam S_IDLE = 2'b00;
  localparam S_INIT = 2'b01;
  localparam S_FG   = 2'b10;
  localparam S_BG   = 2'b11;

  reg [7:0]                    cfg_a_reg;
  reg [7:0]                    cfg_b_reg;
  reg [7:0]                    bg_ctrl_reg;
  reg [7:0]                    pat_ovr_reg;
  reg [1:0]                    state_reg;
  reg [1:0]                    state_next;
  reg [7:0]                    count_reg;
  reg [7:0]                    count_next;
  reg                          first_done_reg;
  reg [`ACC_VEC_PTR_W-1:0]     ptr_reg;
  reg [`ACC_VEC_PTR_W-1:0]     ptr_next;
  reg                          ts_meta_reg;
  reg                          ts_sync_reg;
  reg [`ACC_SAMPLE_W-1:0]      pattern_reg;
  wire [7:0]                   vec_rd_data;
  wire                         bg_busy;
  wire                         vec_en;
  wire                         vec_hit;
  wire                         vec_wr;
  wire                         vec_rd;
  wire                         cal_wr_ok;

  assign bg_busy   = (state_reg == S_BG);
  assign cal_wr_ok = REG_WR_IN && !bg_busy;
  assign vec_en    = cfg_a_reg[`ACC_BIT_VEC_ACCESS_EN];
  assign vec_hit   = (REG_ADDR_IN == `ACC_OFS_VECTOR) && vec_en;
  assign vec_wr    = vec_hit && cal_wr_ok;
  assign vec_rd    = vec_hit && REG_RD_IN && !REG_WR_IN;

  // Pointer advances per access, rewinds when access disabled
  always @*
  begin
    ptr_next = ptr_reg;
    if (!vec_en)
    begin
      ptr_next = {`ACC_VEC_PTR_W{1'b0}};
    end
    else if (vec_wr || vec_rd)
    begin
      ptr_next = ptr_reg + 1'b1;
    end
  end

  acc_vec_mem u_vec_mem
  (
    .clk_in      (CLK_IN),
    .wr_en_in    (vec_wr),
    .wr_addr_in  (ptr_reg),
    .wr_data_in  (REG_WDATA_IN),
    .rd_addr_in  (ptr_next),
    .rd_data_out (vec_rd_data)
  );

  // Register writes; write of trigger wins over its self-clear
  always @(posedge CLK_IN or posedge RESET_IN)
  begin
    if (RESET_IN)
    begin
      cfg_a_reg   <= `ACC_RST_CFG_A;
      cfg_b_reg   <= `ACC_RST_CFG_B;
      bg_ctrl_reg <= `ACC_RST_BG_CTRL;
      pat_ovr_reg <= `ACC_RST_PAT_OVR;
      ptr_reg     <= {`ACC_VEC_PTR_W{1'b0}};
    end
    else
    begin
      ptr_reg <= ptr_next;
      if (cal_wr_ok && REG_ADDR_IN == `ACC_OFS_CFG_A)
      begin
        cfg_a_reg <= REG_WDATA_IN;
      end
      else if (state_reg == S_INIT)
      begin
        cfg_a_reg[`ACC_BIT_FG_TRIGGER] <= 1'b0;
      end
      if (cal_wr_ok && REG_ADDR_IN == `ACC_OFS_CFG_B)
      begin
        cfg_b_reg <= REG_WDATA_IN;
      end
      if (REG_WR_IN && REG_ADDR_IN == `ACC_OFS_BG_CTRL)
      begin
        if (bg_busy)
        begin
          bg_ctrl_reg[`ACC_BIT_BG_RUN] <= REG_WDATA_IN[`ACC_BIT_BG_RUN];
        end
        else
        begin
          bg_ctrl_reg <= REG_WDATA_IN;
        end
      end
      if (REG_WR_IN && REG_ADDR_IN == `ACC_OFS_PAT_OVR)
      begin
        pat_ovr_reg <= REG_WDATA_IN;
      end
    end
  end

  // Calibration sequencer
  always @*
  begin
    state_next = state_reg;
    count_next = count_reg;
    if (cfg_a_reg[`ACC_BIT_FG_TRIGGER] && state_reg != S_INIT)
    begin
      state_next = S_INIT;
      count_next = 8'h00;
    end
    else
    begin
      case (state_reg)
        S_IDLE:
        begin
          count_next = 8'h00;
          if (bg_ctrl_reg[`ACC_BIT_BG_MODE] && bg_ctrl_reg[`ACC_BIT_BG_RUN])
          begin
            state_next = S_BG;
          end
        end
        S_INIT:
        begin
          state_next = S_FG;
          count_next = 8'h00;
        end
        S_FG:
        begin
          count_next = count_reg + 8'h01;
          if (count_reg == `ACC_FG_CAL_CYCLES - 8'h01)
          begin
            state_next = S_IDLE;
            count_next = 8'h00;
          end
        end
        S_BG:
        begin
          count_next = count_reg + 8'h01;
          if (count_reg == `ACC_BG_STEP_CYCLES - 8'h01)
          begin
            count_next = 8'h00;
            if (!(bg_ctrl_reg[`ACC_BIT_BG_MODE] && bg_ctrl_reg[`ACC_BIT_BG_RUN]))
            begin
              state_next = S_IDLE;
            end
          end
        end
        default:
        begin
          state_next = S_IDLE;
          count_next = 8'h00;
        end
      endcase
    end
  end

  always @(posedge CLK_IN or posedge RESET_IN)
  begin
    if (RESET_IN)
    begin
      state_reg      <= S_IDLE;
      count_reg      <= 8'h00;
      first_done_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      count_reg <= count_next;
      if (state_reg == S_FG && state_next == S_IDLE)
      begin
        first_done_reg <= 1'b1;
      end
    end
  end

  // Read port
  always @(posedge CLK_IN or posedge RESET_IN)
  begin
    if (RESET_IN)
    begin
      REG_RDATA_OUT <= 8'h00;
    end
    else if (REG_RD_IN)
    begin
      case (REG_ADDR_IN)
        `ACC_OFS_CFG_A:   REG_RDATA_OUT <= cfg_a_reg;
        `ACC_OFS_CFG_B:   REG_RDATA_OUT <= cfg_b_reg;
        `ACC_OFS_BG_CTRL: REG_RDATA_OUT <= bg_ctrl_reg;
        `ACC_OFS_PAT_OVR: REG_RDATA_OUT <= pat_ovr_reg;
        `ACC_OFS_VECTOR:  REG_RDATA_OUT <= vec_en ? vec_rd_data : 8'h00;
        `ACC_OFS_STATUS:
        begin
          REG_RDATA_OUT <= `ACC_STATUS_FIXED;
          REG_RDATA_OUT[`ACC_BIT_STAT_CAL_OFF] <= (state_reg == S_IDLE);
          REG_RDATA_OUT[`ACC_BIT_STAT_FIRST]   <= first_done_reg;
        end
        default:          REG_RDATA_OUT <= 8'h00;
      endcase
    end
  end

  // Data path outputs
  always @(posedge CLK_IN or posedge RESET_IN)
  begin
    if (RESET_IN)
    begin
      ts_meta_reg               <= 1'b0;
      ts_sync_reg               <= 1'b0;
      pattern_reg               <= {`ACC_SAMPLE_W{1'b0}};
      DATA_OUT                  <= {`ACC_SAMPLE_W{1'b0}};
      TIME_STAMP_OUT            <= 1'b0;
      OVER_RANGE_OUT            <= 1'b0;
      SIGNAL_RANGE_OPTIMIZE_OUT <= 3'h7;
      CAL_RUNNING_OUT           <= 1'b0;
    end
    else
    begin
      ts_meta_reg    <= TIME_STAMP_IN;
      ts_sync_reg    <= ts_meta_reg;
      TIME_STAMP_OUT <= ts_sync_reg && cfg_a_reg[`ACC_BIT_TIME_STAMP_EN];
      pattern_reg    <= pattern_reg + 1'b1;
      if (pat_ovr_reg[`ACC_BIT_TEST_PATTERN])
      begin
        DATA_OUT <= pattern_reg;
      end
      else
      begin
        DATA_OUT <= SAMPLE_IN;
      end
      OVER_RANGE_OUT <= OVER_RANGE_IN && pat_ovr_reg[`ACC_BIT_OVER_RANGE];
      SIGNAL_RANGE_OPTIMIZE_OUT <= cfg_b_reg[`ACC_FLD_RANGE_HI:`ACC_FLD_RANGE_LO];
      CAL_RUNNING_OUT <= (state_next != S_IDLE);
    end
  end

endmodule

//--- testbench/acc_cal_ctrl_sva.sv
// Port assertions for the calibration control bank
`timescale 1ns/1ns
`include "acc_regs.vh"
module acc_cal_ctrl_sva
(
  input wire        CLK_IN,
  input wire        RESET_IN,
  input wire [9:0]  REG_ADDR_IN,
  input wire        REG_WR_IN,
  input wire        REG_RD_IN,
  input wire [7:0]  REG_WDATA_IN,
  input wire [7:0]  REG_RDATA_OUT,
  input wire        TIME_STAMP_IN,
  input wire [11:0] SAMPLE_IN,
  input wire        OVER_RANGE_IN,
  input wire [11:0] DATA_OUT,
  input wire        TIME_STAMP_OUT,
  input wire        OVER_RANGE_OUT,
  input wire [2:0]  SIGNAL_RANGE_OPTIMIZE_OUT,
  input wire        CAL_RUNNING_OUT
);
  reg  ts_en_reg;
  reg  ovr_en_reg;
  reg  pat_en_reg;
  wire wr_a = REG_WR_IN && REG_ADDR_IN == `ACC_OFS_CFG_A;
  wire wr_b = REG_WR_IN && REG_ADDR_IN == `ACC_OFS_CFG_B;
  wire wr_p = REG_WR_IN && REG_ADDR_IN == `ACC_OFS_PAT_OVR;
  wire wr_g = REG_WR_IN && REG_ADDR_IN == `ACC_OFS_BG_CTRL;
  wire mapped = REG_ADDR_IN == `ACC_OFS_CFG_A || REG_ADDR_IN == `ACC_OFS_CFG_B
    || REG_ADDR_IN == `ACC_OFS_BG_CTRL || REG_ADDR_IN == `ACC_OFS_PAT_OVR
    || REG_ADDR_IN == `ACC_OFS_VECTOR || REG_ADDR_IN == `ACC_OFS_STATUS;
  // Shadow enables; bench never writes 0x050 in background
  always @(posedge CLK_IN or posedge RESET_IN)
    if (RESET_IN)
    begin
      ts_en_reg  <= 1'b0;
      ovr_en_reg <= 1'b0;
      pat_en_reg <= 1'b0;
    end
    else
    begin
      if (wr_a)
        ts_en_reg <= REG_WDATA_IN[5];
      if (wr_p)
      begin
        ovr_en_reg <= REG_WDATA_IN[1];
        pat_en_reg <= REG_WDATA_IN[2];
      end
    end
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (RESET_IN);
  a_stamp_gated: assert property (TIME_STAMP_OUT ==
    ($past(TIME_STAMP_IN, 3) & $past(ts_en_reg))) else $error("time stamp wrong");
  a_over_range: assert property (OVER_RANGE_OUT ==
    ($past(OVER_RANGE_IN) & $past(ovr_en_reg))) else $error("over-range wrong");
  a_sample_pass: assert property (!$past(RESET_IN) && !$past(pat_en_reg)
    |-> DATA_OUT == $past(SAMPLE_IN)) else $error("sample not passed");
  a_pattern_ramp: assert property ($past(pat_en_reg) && $past(pat_en_reg, 2)
    |-> DATA_OUT == $past(DATA_OUT) + 12'h001) else $error("ramp broken");
  a_range_write: assert property ((wr_b && !CAL_RUNNING_OUT) ##1 !REG_WR_IN
    |=> SIGNAL_RANGE_OPTIMIZE_OUT == $past(REG_WDATA_IN[6:4], 2)) else $error("range wrong");
  a_fg_start: assert property (wr_a && REG_WDATA_IN[3]
    |-> ##[1:2] CAL_RUNNING_OUT [*8]) else $error("trigger did not run");
  a_bg_stop: assert property (wr_g && !REG_WDATA_IN[1]
    |-> ##[1:70] !CAL_RUNNING_OUT) else $error("run did not stop");
  a_unmapped_zero: assert property (REG_RD_IN && !mapped |=> REG_RDATA_OUT == 8'h00)
    else $error("unmapped read not zero");
endmodule

bind acc_cal_ctrl acc_cal_ctrl_sva chk
(
  .CLK_IN(CLK_IN), .RESET_IN(RESET_IN), .REG_ADDR_IN(REG_ADDR_IN), .REG_WR_IN(REG_WR_IN),
  .REG_RD_IN(REG_RD_IN), .REG_WDATA_IN(REG_WDATA_IN), .REG_RDATA_OUT(REG_RDATA_OUT),
  .TIME_STAMP_IN(TIME_STAMP_IN), .SAMPLE_IN(SAMPLE_IN), .OVER_RANGE_IN(OVER_RANGE_IN),
  .DATA_OUT(DATA_OUT), .TIME_STAMP_OUT(TIME_STAMP_OUT), .OVER_RANGE_OUT(OVER_RANGE_OUT),
  .SIGNAL_RANGE_OPTIMIZE_OUT(SIGNAL_RANGE_OPTIMIZE_OUT), .CAL_RUNNING_OUT(CAL_RUNNING_OUT)
);

//--- testbench/acc_cal_ctrl_tb_top.sv
// Self-checking bench for the calibration control bank
`timescale 1ns/1ns
`include "acc_regs.vh"
module acc_cal_ctrl_tb_top;
  reg         clk = 1'b0;
  reg         rst = 1'b1;
  reg  [9:0]  addr = 10'h000;
  reg         wr_s = 1'b0;
  reg         rd_s = 1'b0;
  reg  [7:0]  wdata = 8'h00;
  reg         ts_in = 1'b0;
  reg  [11:0] sample = 12'hA5C;
  reg         ovr_in = 1'b0;
  wire [7:0]  rdata;
  wire [11:0] data_out;
  wire        ts_out;
  wire        ovr_out;
  wire        running;
  wire [2:0]  range;
  integer     n_errors = 0;
  integer     cmp_count = 0;
  integer     cyc = 0;
  integer     i;
  always #5 clk = ~clk;
  acc_cal_ctrl uut
  (
    .CLK_IN(clk), .RESET_IN(rst), .REG_ADDR_IN(addr), .REG_WR_IN(wr_s), .REG_RD_IN(rd_s),
    .REG_WDATA_IN(wdata), .REG_RDATA_OUT(rdata), .TIME_STAMP_IN(ts_in), .SAMPLE_IN(sample),
    .OVER_RANGE_IN(ovr_in), .DATA_OUT(data_out), .TIME_STAMP_OUT(ts_out),
    .OVER_RANGE_OUT(ovr_out), .SIGNAL_RANGE_OPTIMIZE_OUT(range), .CAL_RUNNING_OUT(running)
  );
  task chk(input [11:0] got, input [11:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp)
      begin
        n_errors = n_errors + 1;
        $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [9:0] a, input [7:0] d);
    begin
      @(negedge clk);
      addr = a;
      wdata = d;
      wr_s = 1'b1;
      @(negedge clk);
      wr_s = 1'b0;
    end
  endtask
  task rd(input [9:0] a, input [7:0] e);
    begin
      @(negedge clk);
      addr = a;
      rd_s = 1'b1;
      @(negedge clk);
      rd_s = 1'b0;
      chk({4'h0, rdata}, {4'h0, e});
    end
  endtask
  task end_of_test;
    begin
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == 3000)
    begin
      n_errors = n_errors + 1;
      end_of_test;
    end
  end
  initial
  begin
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    rd(`ACC_OFS_CFG_A, 8'h06);
    rd(`ACC_OFS_CFG_B, 8'hF4);
    rd(`ACC_OFS_BG_CTRL, 8'h10);
    rd(`ACC_OFS_PAT_OVR, 8'h00);
    rd(10'h052, 8'h00);
    rd(`ACC_OFS_VECTOR, 8'h00);
    chk({9'h000, range}, 12'h007);
    ovr_in = 1'b1;
    wr(`ACC_OFS_PAT_OVR, 8'h06);
    repeat (3) @(negedge clk);
    chk({11'h000, ovr_out}, 12'h001);
    wr(`ACC_OFS_PAT_OVR, 8'h00);
    @(negedge clk);
    chk(data_out, sample);
    ts_in = 1'b1;
    wr(`ACC_OFS_CFG_A, 8'h26);
    repeat (4) @(negedge clk);
    chk({11'h000, ts_out}, 12'h001);
    wr(`ACC_OFS_CFG_A, 8'h16);
    for (i = 0; i < 16; i = i + 1)
      wr(`ACC_OFS_VECTOR, {4'h0, i[3:0]} ^ 8'h5A);
    for (i = 0; i < 17; i = i + 1)
      rd(`ACC_OFS_VECTOR, {4'h0, i[3:0]} ^ 8'h5A);
    wr(`ACC_OFS_CFG_A, 8'h06);
    wr(`ACC_OFS_VECTOR, 8'hFF);
    rd(`ACC_OFS_VECTOR, 8'h00);
    wr(`ACC_OFS_CFG_A, 8'h16);
    rd(`ACC_OFS_VECTOR, 8'h5A);
    wr(`ACC_OFS_CFG_A, 8'h06);
    wr(`ACC_OFS_CFG_B, 8'h84);
    repeat (2) @(negedge clk);
    chk({9'h000, range}, 12'h000);
    wr(`ACC_OFS_CFG_A, 8'h0E);
    rd(`ACC_OFS_STATUS, 8'h08);
    rd(`ACC_OFS_CFG_A, 8'h06);
    repeat (70) @(negedge clk);
    rd(`ACC_OFS_STATUS, 8'h0B);
    wr(`ACC_OFS_BG_CTRL, 8'h13);
    rd(`ACC_OFS_STATUS, 8'h09);
    wr(`ACC_OFS_CFG_B, 8'hF4);
    rd(`ACC_OFS_CFG_B, 8'h84);
    wr(`ACC_OFS_BG_CTRL, 8'h10);
    rd(`ACC_OFS_BG_CTRL, 8'h11);
    repeat (20) @(negedge clk);
    rd(`ACC_OFS_STATUS, 8'h0B);
    wr(`ACC_OFS_BG_CTRL, 8'h10);
    rd(`ACC_OFS_BG_CTRL, 8'h10);
    wr(`ACC_OFS_CFG_A, 8'h0E);
    @(negedge clk);
    chk({11'h000, running}, 12'h001);
    repeat (70) @(negedge clk);
    end_of_test;
  end
endmodule
